/* design/srp_map.svh */
// Purpose: shared constants of the pipelined static memory port
// Assumes: included by bare name
// Notes:   timing figures are in clock cycles
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH
// =====================================================================
// geometry
`define SRP_ADDR_W        21
`define SRP_LANES         4
`define SRP_LANE_W        9
// =====================================================================
// timing
`define SRP_SLEEP_ENTER   2'h2
`define SRP_SLEEP_EXIT    2'h2
`define SRP_WAKE_GUARD    2'h3
`endif

/* design/srp_pkg.sv */
// Purpose: types of the device end of the memory port, shared with the bench
// Assumes: nothing
// Notes:   no constants here, see srp_map.svh
package srp_pkg;
  typedef enum logic [1:0] {SRP_OP_DESEL, SRP_OP_READ, SRP_OP_WRITE} srp_op_type;
  typedef enum logic [1:0] {SRP_RUN, SRP_ENTER, SRP_ASLEEP, SRP_WAKE} srp_sleep_type;
endpackage

/* design/srp_if.sv */
// Purpose: pins between memory controller and memory device
// Assumes: one clock shared by both ends
// Notes:   data wire resolved here from the two enables
`timescale 1ns/1ns
interface srp_if #(
  parameter int ADDR_W = 21,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
);
  localparam int DATA_W = LANES * LANE_W;
  logic [ADDR_W-1:0] addr;
  logic              advanceLoadN;
  logic              writeEnN;
  logic              clkEnableN;
  logic              chipSelFirstN;
  logic              chipSelSecond;
  logic              chipSelThirdN;
  logic [LANES-1:0]  byteWriteN;
  logic              outEnN;
  logic              burstOrderSel;
  logic              sleepRequest;
  logic [DATA_W-1:0] ctrlDq;
  logic              ctrlDqOe;
  logic [DATA_W-1:0] devDq;
  logic              devDqOe;
  wire  [DATA_W-1:0] dq;
  // released wire reads as zero, no third value in the carrier
  assign dq = devDqOe ? devDq : (ctrlDqOe ? ctrlDq : '0);
  modport dev (input addr, advanceLoadN, writeEnN, clkEnableN, chipSelFirstN, chipSelSecond,
               chipSelThirdN, byteWriteN, outEnN, burstOrderSel, sleepRequest, dq,
               output devDq, devDqOe);
  modport ctrl (output addr, advanceLoadN, writeEnN, clkEnableN, chipSelFirstN, chipSelSecond,
                chipSelThirdN, byteWriteN, outEnN, burstOrderSel, sleepRequest, ctrlDq, ctrlDqOe,
                input dq);
endinterface // srp_if

/* design/srp_mem_ctrl.sv */
// Purpose: controller end, turns user requests into port pin cycles
// Assumes: user holds burstOrder static
// Notes:   pipelines advance only on edges the device takes
`timescale 1ns/1ns
`include "srp_map.svh"
module srp_mem_ctrl #(
  parameter int ADDR_W = `SRP_ADDR_W,
  parameter int LANES  = `SRP_LANES,
  parameter int LANE_W = `SRP_LANE_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  srp_if.ctrl                           bus,
  input  wire logic                     reqValid,
  output logic                          reqReady,
  input  wire logic                     reqWrite,
  input  wire logic                     reqBurst,
  input  wire logic [ADDR_W-1:0]        reqAddr,
  input  wire logic [LANES-1:0]         reqByteEn,
  input  wire logic [LANES*LANE_W-1:0]  reqWdata,
  input  wire logic                     suspend,
  input  wire logic                     sleepCmd,
  input  wire logic                     burstOrder,
  input  wire logic                     dataOutEnable,
  output logic                          rspValid,
  output logic [LANES*LANE_W-1:0]       rspData,
  output logic                          sleepBusy
);
  localparam int DATA_W = LANES * LANE_W;
  logic [ADDR_W-1:0] addr_ff;
  logic              advN_ff, weN_ff, cs1N_ff, ckeN_ff, oeN_ff, sleep_ff;
  logic [LANES-1:0]  bwN_ff;
  logic              p0Valid_ff, p0Write_ff, p1Valid_ff, p1Write_ff, p2Read_ff, p2Fresh_ff;
  logic [DATA_W-1:0] p0Wdata_ff, p1Wdata_ff, dq_ff, rsp_ff;
  logic              dqOe_ff, rspValid_ff, lastDesel_ff, lastWrite_ff;
  logic [1:0]        wakeCnt_ff;
  wire step      = ~ckeN_ff;
  wire pipeIdle  = ~p0Valid_ff & ~p1Valid_ff & ~p2Read_ff & ~dqOe_ff;
  wire sleepHold = sleepCmd | sleep_ff | (wakeCnt_ff != 2'h0);
  // burst only after a fresh load
  assign reqReady = step & ~sleepHold & (~reqBurst | ~lastDesel_ff);
  wire issue     = reqValid & reqReady;
  wire issueWr   = reqBurst ? lastWrite_ff : reqWrite;
  // =====================================================================
  // pins
  assign bus.addr          = addr_ff;
  assign bus.advanceLoadN  = advN_ff;
  assign bus.writeEnN      = weN_ff;
  assign bus.clkEnableN    = ckeN_ff;
  // only the first select is used for deselect
  assign bus.chipSelFirstN = cs1N_ff;
  assign bus.chipSelSecond = 1'b1;
  assign bus.chipSelThirdN = 1'b0;
  assign bus.byteWriteN    = bwN_ff;
  assign bus.outEnN        = oeN_ff;
  assign bus.burstOrderSel = burstOrder;
  assign bus.sleepRequest  = sleep_ff;
  assign bus.ctrlDq        = dq_ff;
  assign bus.ctrlDqOe      = dqOe_ff;
  assign rspValid          = rspValid_ff;
  assign rspData           = rsp_ff;
  assign sleepBusy         = sleepHold;
  // =====================================================================
  // command stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_ff <= '0; advN_ff <= 1'b0; weN_ff <= 1'b1; cs1N_ff <= 1'b1; bwN_ff <= '1;
      p0Valid_ff <= 1'b0; p0Write_ff <= 1'b0; p0Wdata_ff <= '0;
      lastDesel_ff <= 1'b1; lastWrite_ff <= 1'b0;
    end
    else if (step)
    begin
      advN_ff    <= issue & reqBurst;
      cs1N_ff    <= ~issue;
      weN_ff     <= ~(issue & issueWr);
      p0Valid_ff <= issue;
      p0Write_ff <= issue & issueWr;
      if (issue)
      begin
        addr_ff      <= reqAddr;
        bwN_ff       <= ~reqByteEn;
        p0Wdata_ff   <= reqWdata;
        lastWrite_ff <= issueWr;
      end
      lastDesel_ff <= ~issue;
    end
  end
  // =====================================================================
  // data pipeline
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      p1Valid_ff <= 1'b0; p1Write_ff <= 1'b0; p1Wdata_ff <= '0; p2Read_ff <= 1'b0;
      p2Fresh_ff <= 1'b0; dq_ff <= '0; dqOe_ff <= 1'b0; rspValid_ff <= 1'b0; rsp_ff <= '0;
    end
    else
    begin
      p2Fresh_ff  <= step;
      rspValid_ff <= p2Fresh_ff & p2Read_ff;
      if (p2Fresh_ff & p2Read_ff)
        rsp_ff <= bus.dq;
      if (step)
      begin
        p1Valid_ff <= p0Valid_ff;
        p1Write_ff <= p0Write_ff;
        p1Wdata_ff <= p0Wdata_ff;
        p2Read_ff  <= p1Valid_ff & ~p1Write_ff;
        // write data two taken edges after its address
        dq_ff      <= p1Wdata_ff;
        dqOe_ff    <= p1Write_ff;
      end
    end
  end
  // =====================================================================
  // suspend, output enable, sleep
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ckeN_ff <= 1'b0; oeN_ff <= 1'b1; sleep_ff <= 1'b0; wakeCnt_ff <= 2'h0;
    end
    else
    begin
      ckeN_ff <= suspend;
      oeN_ff  <= ~dataOutEnable;
      // sleep only with the pipeline drained
      sleep_ff <= sleepCmd & (sleep_ff | pipeIdle);
      if (sleep_ff)
        wakeCnt_ff <= `SRP_WAKE_GUARD;
      else if (wakeCnt_ff != 2'h0)
        wakeCnt_ff <= wakeCnt_ff - 2'h1;
    end
  end
endmodule // srp_mem_ctrl

/* design/srp_sram_device.sv */
// Purpose: device end, pipelined synchronous static memory with no turnaround
// Assumes: controller keeps its side of the port protocol
// Notes:   no forwarding from a write still in its data wait
`timescale 1ns/1ns
`include "srp_map.svh"
// Functional notes
// - inputs sampled on rising edge, three asynchronous
// - clock enable high freezes every register except the sleep control state
// - load needs enable, load, all selects
// - controller reloads address after a deselect
// - read data driven from second edge
// - output enable high floats data outputs
// - write data follows address by two cycles
// - byte enables commit own lane only
// - advance continues at next burst address
// - linear or exclusive-or burst order
// - low address bits seed burst counter
// - continue-deselect only after a deselect
// - sleep entered two cycles after request
// - wake two cycles after request drops
// - controller keeps sleep low in operation
// - burst order input held fixed
// - reads and writes back to back
// - asleep ignores inputs, floats outputs
// - controller issues no writes while waking
module srp_sram_device #(
  parameter int ADDR_W = `SRP_ADDR_W,
  parameter int LANES  = `SRP_LANES,
  parameter int LANE_W = `SRP_LANE_W
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  srp_if.dev               bus,
  output logic             sleepActive,
  output srp_pkg::srp_op_type opState
);
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH  = 1 << ADDR_W;

  // =====================================================================
  // command decode
  srp_pkg::srp_sleep_type sleep_ff;
  srp_pkg::srp_sleep_type nxt_sleep;
  logic [1:0]             sleepCnt_ff;
  logic [1:0]             nxt_sleepCnt;
  srp_pkg::srp_op_type    op_ff;
  srp_pkg::srp_op_type    nxt_op;

  wire awake     = (sleep_ff == srp_pkg::SRP_RUN) || (sleep_ff == srp_pkg::SRP_ENTER);
  wire pinEn     = ~bus.clkEnableN & awake;
  wire selected  = ~bus.chipSelFirstN & bus.chipSelSecond & ~bus.chipSelThirdN;
  wire loadCmd   = pinEn & ~bus.advanceLoadN & selected;
  wire deselCmd  = pinEn & ~bus.advanceLoadN & ~selected;
  wire advCmd    = pinEn & bus.advanceLoadN;
  // advance out of deselect stays deselected
  wire advActive = advCmd & (op_ff != srp_pkg::SRP_OP_DESEL);

  // =====================================================================
  // burst address
  logic [ADDR_W-3:0] base_ff;
  logic [1:0]        start_ff;
  logic [1:0]        cnt_ff;
  wire  [1:0]        cntNext = cnt_ff + 2'h1;
  // order input read without a clock
  wire  [1:0]        beatLow = bus.burstOrderSel ? (start_ff ^ cntNext) : (start_ff + cntNext);
  // next beat address from the counter
  wire  [ADDR_W-1:0] accAddr = loadCmd ? bus.addr : {base_ff, beatLow};
  wire               loadWr  = ~bus.writeEnN;
  wire               beatWr  = loadCmd ? loadWr : (op_ff == srp_pkg::SRP_OP_WRITE);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      base_ff  <= '0;
      start_ff <= 2'h0;
      cnt_ff   <= 2'h0;
    end
    else if (loadCmd)
    begin
      base_ff  <= bus.addr[ADDR_W-1:2];
      start_ff <= bus.addr[1:0];
      cnt_ff   <= 2'h0;
    end
    else if (advActive)
    begin
      // wraps after four beats by width
      cnt_ff <= cntNext;
    end
  end

  // =====================================================================
  // operation state
  always_comb
  begin
    nxt_op = op_ff;
    if (loadCmd)
      nxt_op = loadWr ? srp_pkg::SRP_OP_WRITE : srp_pkg::SRP_OP_READ;
    else if (deselCmd)
      nxt_op = srp_pkg::SRP_OP_DESEL;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      op_ff <= srp_pkg::SRP_OP_DESEL;
    else
      op_ff <= nxt_op;
  end

  // =====================================================================
  // pipeline stages
  logic              s1Valid_ff, s1Write_ff, s2Valid_ff, s2Write_ff, rdValid_ff;
  logic [ADDR_W-1:0] s1Addr_ff, s2Addr_ff;
  logic [LANES-1:0]  s1ByteN_ff, s2ByteN_ff;
  wire  [LANES-1:0]  beatByteN = beatWr ? bus.byteWriteN : {LANES{1'b1}};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1Valid_ff <= 1'b0;
      s1Write_ff <= 1'b0;
      s1Addr_ff  <= '0;
      s1ByteN_ff <= '1;
    end
    else if (pinEn)
    begin
      // reloads every enabled edge, a valid beat only on a load or an active advance
      s1Valid_ff <= loadCmd | advActive;
      s1Write_ff <= beatWr;
      s1Addr_ff  <= accAddr;
      s1ByteN_ff <= beatByteN;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s2Valid_ff <= 1'b0;
      s2Write_ff <= 1'b0;
      s2Addr_ff  <= '0;
      s2ByteN_ff <= '1;
      rdValid_ff <= 1'b0;
    end
    else if (pinEn)
    begin
      s2Valid_ff <= s1Valid_ff;
      s2Write_ff <= s1Write_ff;
      s2Addr_ff  <= s1Addr_ff;
      s2ByteN_ff <= s1ByteN_ff;
      // only reads turn the drivers on
      rdValid_ff <= s1Valid_ff & ~s1Write_ff;
    end
  end

  // =====================================================================
  // storage lanes
  wire [DATA_W-1:0] rdData;

  for (genvar g = 0; g < LANES; g++)
  begin : gLane
    // data byte plus extra bit per lane
    logic [LANE_W-1:0] laneMem [0:DEPTH-1];
    logic [LANE_W-1:0] rdLane_ff;
    // commit at the data edge per lane
    wire laneWr = pinEn & s2Valid_ff & s2Write_ff & ~s2ByteN_ff[g];

    always_ff @(posedge ref_clk)
    begin
      if (laneWr)
        laneMem[s2Addr_ff] <= bus.dq[g*LANE_W +: LANE_W];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        rdLane_ff <= '0;
      else if (pinEn & s1Valid_ff & ~s1Write_ff)
        rdLane_ff <= laneMem[s1Addr_ff];
    end

    assign rdData[g*LANE_W +: LANE_W] = rdLane_ff;
  end

  // =====================================================================
  // output drivers
  assign bus.devDq   = rdData;
  // output enable and sleep act at once
  assign bus.devDqOe = rdValid_ff & ~bus.outEnN & (sleep_ff != srp_pkg::SRP_ASLEEP);
  assign sleepActive = (sleep_ff == srp_pkg::SRP_ASLEEP);
  assign opState     = op_ff;

  // =====================================================================
  // sleep control
  always_comb
  begin
    nxt_sleep    = sleep_ff;
    nxt_sleepCnt = 2'h0;
    case (sleep_ff)
      srp_pkg::SRP_RUN:
        if (bus.sleepRequest)
          nxt_sleep = srp_pkg::SRP_ENTER;
      srp_pkg::SRP_ENTER:
        if (!bus.sleepRequest)
          nxt_sleep = srp_pkg::SRP_RUN;
        else if (sleepCnt_ff == `SRP_SLEEP_ENTER - 2'h1)
          nxt_sleep = srp_pkg::SRP_ASLEEP;
        else
          nxt_sleepCnt = sleepCnt_ff + 2'h1;
      srp_pkg::SRP_ASLEEP:
        if (!bus.sleepRequest)
          nxt_sleep = srp_pkg::SRP_WAKE;
      srp_pkg::SRP_WAKE:
        if (bus.sleepRequest)
          nxt_sleep = srp_pkg::SRP_ASLEEP;
        else if (sleepCnt_ff == `SRP_SLEEP_EXIT - 2'h1)
          nxt_sleep = srp_pkg::SRP_RUN;
        else
          nxt_sleepCnt = sleepCnt_ff + 2'h1;
      default:
        nxt_sleep = srp_pkg::SRP_RUN;
    endcase
  end

  // internal state survives sleep since pinEn holds it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_ff    <= srp_pkg::SRP_RUN;
      sleepCnt_ff <= 2'h0;
    end
    else
    begin
      sleep_ff    <= nxt_sleep;
      sleepCnt_ff <= nxt_sleepCnt;
    end
  end
endmodule // srp_sram_device

/* bench/srp_properties.sv */
// Purpose: pin-level properties of the memory port
// Assumes: both ends are design modules on one shared clock
// Notes:   edges near sleep and wake are left out of the load checks
`timescale 1ns/1ns
module srp_properties #(
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    advanceLoadN,
  input wire logic                    writeEnN,
  input wire logic                    clkEnableN,
  input wire logic                    chipSelFirstN,
  input wire logic                    chipSelSecond,
  input wire logic                    chipSelThirdN,
  input wire logic                    outEnN,
  input wire logic                    sleepRequest,
  input wire logic                    ctrlDqOe,
  input wire logic [LANES*LANE_W-1:0] devDq,
  input wire logic                    devDqOe,
  input wire logic                    sleepActive,
  input wire srp_pkg::srp_op_type     opState
);
  logic [1:0] calm_ff;
  wire        awake;
  wire        take;
  wire        sel;
  wire        loadRd;
  wire        loadWr;

  // ==========================================================
  // helpers
  // device takes inputs again only three edges after sleep drops
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      calm_ff <= 2'h0;
    else if (sleepRequest)
      calm_ff <= 2'h0;
    else if (calm_ff != 2'h3)
      calm_ff <= calm_ff + 2'h1;

  assign awake  = (calm_ff == 2'h3) && !sleepRequest;
  assign take   = !clkEnableN && awake;
  assign sel    = !chipSelFirstN && chipSelSecond && !chipSelThirdN;
  assign loadRd = take && !advanceLoadN && sel && writeEnN;
  assign loadWr = take && !advanceLoadN && sel && !writeEnN;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // properties
  a_read_drive: assert property (loadRd ##1 take |-> ##1 (devDqOe || outEnN))
    else $error("read data not driven after second edge");
  a_oe_floats: assert property (outEnN |-> !devDqOe)
    else $error("data driven with output enable off");
  a_sleep_floats: assert property (sleepActive |-> !devDqOe)
    else $error("data driven while asleep");
  a_write_quiet: assert property (loadWr ##1 take |-> ##1 !devDqOe)
    else $error("device drives data during write");
  a_write_data: assert property (loadWr ##1 take ##1 take |-> ctrlDqOe)
    else $error("write data not on wire two edges after load");
  a_suspend_hold: assert property (clkEnableN |=> $stable(devDq) && $stable(opState))
    else $error("state moved on a suspended edge");
  a_load_read: assert property (loadRd |=> opState == srp_pkg::SRP_OP_READ)
    else $error("read load not taken");
  a_load_write: assert property (loadWr |=> opState == srp_pkg::SRP_OP_WRITE)
    else $error("write load not taken");
  a_desel_state: assert property (take && !advanceLoadN && !sel |=> opState == srp_pkg::SRP_OP_DESEL)
    else $error("inactive select did not deselect");
  a_burst_hold: assert property (take && advanceLoadN |=> $stable(opState))
    else $error("advance changed the operation");
  a_sleep_enter: assert property ($rose(sleepRequest) |-> !sleepActive[*3] ##1 sleepActive)
    else $error("sleep not entered two edges after request");
endmodule // srp_properties

/* bench/testbench.sv */
// Purpose: self-checking bench for both ends of the memory port
// Assumes: address width cut to 8 bits for short runs
// Notes:   no read follows a write to the same word within two beats
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  localparam int AW = 8;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic        reqBurst = 1'b0;
  logic [7:0]  reqAddr = 8'h00;
  logic [3:0]  reqByteEn = 4'h0;
  logic [35:0] reqWdata = 36'h0_0000_0000;
  logic        suspend = 1'b0;
  logic        sleepCmd = 1'b0;
  logic        burstOrder = 1'b0;
  logic        dataOutEnable = 1'b1;
  logic        reqReady;
  logic        rspValid;
  logic [35:0] rspData;
  logic        sleepBusy;
  logic        sleepActive;
  srp_pkg::srp_op_type opState;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [35:0] refMem [int];
  logic [36:0] expQ [$];
  logic [7:0]  burstStart = 8'h00;
  int          beat = 0;

  always #50 ref_clk = ~ref_clk;

  srp_if #(.ADDR_W(AW)) bus ();
  srp_mem_ctrl #(.ADDR_W(AW)) srp_mem_ctrl_i (.ref_clk(ref_clk), .rst(rst), .bus(bus), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqBurst(reqBurst), .reqAddr(reqAddr), .reqByteEn(reqByteEn),
    .reqWdata(reqWdata), .suspend(suspend), .sleepCmd(sleepCmd), .burstOrder(burstOrder),
    .dataOutEnable(dataOutEnable), .rspValid(rspValid), .rspData(rspData), .sleepBusy(sleepBusy));
  srp_sram_device #(.ADDR_W(AW)) srp_sram_device_i (.ref_clk(ref_clk), .rst(rst), .bus(bus),
    .sleepActive(sleepActive), .opState(opState));
  srp_properties #(.LANES(4), .LANE_W(9)) srp_properties_i (.ref_clk(ref_clk), .rst(rst),
    .advanceLoadN(bus.advanceLoadN), .writeEnN(bus.writeEnN), .clkEnableN(bus.clkEnableN),
    .chipSelFirstN(bus.chipSelFirstN), .chipSelSecond(bus.chipSelSecond), .chipSelThirdN(bus.chipSelThirdN),
    .outEnN(bus.outEnN), .sleepRequest(bus.sleepRequest), .ctrlDqOe(bus.ctrlDqOe), .devDq(bus.devDq),
    .devDqOe(bus.devDqOe), .sleepActive(sleepActive), .opState(opState));

  // ==========================================================
  // access tasks
  // request stays up after return; a back-to-back call overrides it
  task automatic req(input logic w, input logic b, input logic [7:0] a, input logic [3:0] be,
                     input logic [35:0] d);
    logic [7:0] ad;
    ad = a;
    if (b)
    begin
      beat++;
      ad = {burstStart[7:2], burstOrder ? burstStart[1:0] ^ beat[1:0] : burstStart[1:0] + beat[1:0]};
    end
    else
    begin
      burstStart = a;
      beat = 0;
    end
    for (int l = 0; l < 4; l++)
      if (w && be[l])
        refMem[ad][l*9+:9] = d[l*9+:9];
    if (!w)
      expQ.push_back({dataOutEnable, refMem[ad]});
    reqValid  <= 1'b1;
    reqWrite  <= w;
    reqBurst  <= b;
    reqAddr   <= a;
    reqByteEn <= be;
    reqWdata  <= d;
    @(negedge ref_clk);
    while (reqReady !== 1'b1)
      @(negedge ref_clk);
    @(posedge ref_clk);
  endtask

  task automatic idle(input int n);
    reqValid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // an unexpected response counts as a mismatch
  always @(negedge ref_clk)
    if (rspValid === 1'b1)
    begin : rsp
      logic [36:0] e;
      e = 37'h0_0000_0000;
      `CHK(expQ.size() != 0, 1'b1)
      if (expQ.size() > 0)
        e = expQ.pop_front();
      if (e[36])
        `CHK(rspData, e[35:0])
    end

  // ==========================================================
  // tests
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      req(1'b1, 1'b0, 8'h10 + i[7:0], 4'hF, 36'h1_2345_6789 + i);
    idle(3);
    // lane write, abort, then reads and writes mixed back to back
    req(1'b1, 1'b0, 8'h12, 4'h5, 36'hF_0F0F_0F0F);
    req(1'b1, 1'b0, 8'h13, 4'h0, 36'h0_0000_0000);
    req(1'b0, 1'b0, 8'h10, 4'hF, 36'h0_0000_0000);
    req(1'b1, 1'b0, 8'h20, 4'hF, 36'h5_A5A5_A5A5);
    req(1'b0, 1'b0, 8'h11, 4'hF, 36'h0_0000_0000);
    idle(3);
    req(1'b0, 1'b0, 8'h12, 4'hF, 36'h0_0000_0000);
    req(1'b0, 1'b0, 8'h13, 4'hF, 36'h0_0000_0000);
    req(1'b0, 1'b0, 8'h20, 4'hF, 36'h0_0000_0000);
    idle(4);
    // both burst orders; a mid-burst abort must still advance
    for (int m = 0; m < 2; m++)
    begin
      // order changes only while the port is idle
      burstOrder <= m[0];
      idle(2);
      req(1'b1, 1'b0, 8'h15, 4'hF, 36'hA_0000_0000 + m);
      for (int k = 1; k < 4; k++)
        req(1'b1, 1'b1, 8'h00, (k == 2) ? 4'h0 : 4'hF, 36'hA_0000_0000 + 16 * k + m);
      idle(3);
      req(1'b0, 1'b0, 8'h16, 4'hF, 36'h0_0000_0000);
      for (int k = 1; k < 4; k++)
        req(1'b0, 1'b1, 8'h00, 4'hF, 36'h0_0000_0000);
      idle(4);
    end
    // dummy read with outputs disabled
    dataOutEnable <= 1'b0;
    idle(2);
    req(1'b0, 1'b0, 8'h10, 4'hF, 36'h0_0000_0000);
    idle(2);
    @(negedge ref_clk);
    `CHK(bus.devDqOe, 1'b0)
    `CHK(bus.dq, 36'h0_0000_0000)
    @(posedge ref_clk);
    dataOutEnable <= 1'b1;
    idle(4);
    // suspend while a read and a write are in flight
    req(1'b0, 1'b0, 8'h11, 4'hF, 36'h0_0000_0000);
    suspend <= 1'b1;
    idle(3);
    suspend <= 1'b0;
    req(1'b1, 1'b0, 8'h30, 4'hF, 36'h3_0303_0303);
    suspend <= 1'b1;
    idle(2);
    suspend <= 1'b0;
    idle(4);
    req(1'b0, 1'b0, 8'h30, 4'hF, 36'h0_0000_0000);
    idle(6);
    // sleep and wake keep the array
    sleepCmd <= 1'b1;
    for (int n = 0; n < 40 && sleepActive !== 1'b1; n++)
      @(negedge ref_clk);
    `CHK(sleepActive, 1'b1)
    @(posedge ref_clk);
    // sleep request low again for normal operation
    sleepCmd <= 1'b0;
    for (int n = 0; n < 40 && sleepBusy !== 1'b0; n++)
      @(negedge ref_clk);
    `CHK(sleepBusy, 1'b0)
    @(posedge ref_clk);
    // only a read right after wake-up
    req(1'b0, 1'b0, 8'h11, 4'hF, 36'h0_0000_0000);
    idle(8);
    `CHK(expQ.size(), 0)
    wrap_up();
  end

  initial
  begin
    repeat (4000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end
endmodule // testbench
